/* design/dxd_decode.sv */
/*
 * DSP extension instruction unit: decode, execute, register file, AXI4-Lite slave.
 * Assumes a data memory that answers combinationally while mem_ready is high.
 */
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module dxd_decode (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output dxd_pkg::dxd_mem_type mem_out,
    input wire logic mem_ready,
    input wire logic [31:0] mem_rdata
);
    import dxd_pkg::*;

    dxd_state_type state_q;
    logic [15:0] op_q;
    dxd_dec_type dec_q;
    logic taken_q;
    logic [2:0] cnt_q;
    logic [7:0] cyc_q;
    logic [7:0] last_cyc_q;
    logic illegal_q;
    logic [31:0] dsp_q [NUM_DSP];
    logic [31:0] gpr_q [NUM_GPR];
    logic [31:0] status_q;
    logic [31:0] pc_q;
    dxd_mem_type mem_q;
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic aw_hold_q, w_hold_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic [3:0] gpr_idx;
    logic [31:0] disp2;
    logic wr_fire, issue, stall, retire, br_take, idle;
    dxd_dec_type dec_new;

    // ********
    // Decode helpers
    // ********
    function automatic logic [4:0] ctl_sel(input logic [3:0] sel);
        logic [4:0] r;
        r = 5'h00;
        case (sel)
            CTL_SEL_WRAP: r = {1'b1, TGT_WRAP};
            CTL_SEL_START: r = {1'b1, TGT_START};
            CTL_SEL_FIN: r = {1'b1, TGT_FIN};
            default: r = 5'h00;
        endcase
        return r;
    endfunction : ctl_sel

    function automatic logic [4:0] sys_sel(input logic [3:0] sel);
        logic [4:0] r;
        r = 5'h00;
        if (sel >= SYS_SEL_LO && sel <= SYS_SEL_HI) r = {1'b1, 4'(sel - SYS_SEL_BIAS)};
        return r;
    endfunction : sys_sel

    function automatic dxd_dec_type decode(input logic [15:0] op);
        dxd_dec_type d;
        logic [4:0] c;
        logic [4:0] s;
        d = '{K_ILLEGAL, 4'h0, CYC_ONE};
        c = ctl_sel(op[7:4]);
        s = sys_sel(op[7:4]);
        if (op[15:8] == HB_LDFIN_PC) d = '{K_PCREL, TGT_FIN, CYC_ONE};
        else if (op[15:8] == HB_LDST_PC) d = '{K_PCREL, TGT_START, CYC_ONE};
        else if (op[15:8] == HB_CNT_IMM) d = '{K_CNT_IMM, 4'h0, CYC_ONE};
        else if (op[15:8] == HB_BT_S || op[15:8] == HB_BF_S) d = '{K_BRANCH, 4'h0, CYC_BR_TAKEN};
        else if (op[15:12] == GRP_SYS && op[7:0] == LO_CNT_REG) d = '{K_CNT_REG, 4'h0, CYC_ONE};
        else if (op[15:12] == GRP_SYS) begin
            case (op[3:0])
                NIB_CTL_MOVE: if (c[4]) d = '{K_TO_DSP, c[3:0], CYC_ONE};
                NIB_CTL_LOAD: if (c[4]) d = '{K_LOAD, c[3:0], CYC_CTL_LOAD};
                NIB_CTL_STORE: if (c[4]) d = '{K_STORE, c[3:0], CYC_CTL_STORE};
                NIB_SYS_MOVE: if (s[4]) d = '{K_TO_DSP, s[3:0], CYC_ONE};
                NIB_SYS_LOAD: if (s[4]) d = '{K_LOAD, s[3:0], CYC_ONE};
                NIB_SYS_STORE: if (s[4]) d = '{K_STORE, s[3:0], CYC_ONE};
                default: d = '{K_ILLEGAL, 4'h0, CYC_ONE};
            endcase
        end else if (op[15:12] == GRP_MOV) begin
            case (op[3:0])
                NIB_CTL_READ: if (c[4]) d = '{K_FROM_DSP, c[3:0], CYC_ONE};
                NIB_SYS_MOVE: if (s[4]) d = '{K_FROM_DSP, s[3:0], CYC_ONE};
                default: d = '{K_ILLEGAL, 4'h0, CYC_ONE};
            endcase
        end
        return d;
    endfunction : decode

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction : merge

    function automatic logic mapped(input logic [7:0] a);
        return a[1:0] == 2'h0 && (a <= OFS_EXEC || (a >= OFS_GPR_BASE && a <= OFS_GPR_END));
    endfunction : mapped

    function automatic logic [31:0] rd_value(input logic [7:0] a);
        logic [31:0] r;
        r = 32'h0;
        if (!mapped(a)) r = 32'h0;
        else if (a < OFS_STATUS) r = dsp_q[a[5:2]];
        else if (a == OFS_STATUS) r = status_q;
        else if (a == OFS_PC) r = pc_q;
        else if (a == OFS_ISSUE) r = {16'h0, op_q};
        else if (a == OFS_EXEC) begin
            r[EXEC_BUSY_BIT] = state_q == ST_EXEC;
            r[EXEC_ILLEGAL_BIT] = illegal_q;
            r[EXEC_CYC_LSB +: 8] = last_cyc_q;
        end else r = gpr_q[a[5:2]];
        return r;
    endfunction : rd_value

    // ********
    // Control
    // ********
    assign gpr_idx = op_q[11:8];
    assign disp2 = {{23{op_q[7]}}, op_q[7:0], 1'b0};
    assign idle = state_q == ST_IDLE;
    assign wr_fire = clk_en && aw_hold_q && w_hold_q && !bvalid_q;
    assign issue = wr_fire && idle && aw_addr_q == OFS_ISSUE;
    assign dec_new = decode(w_data_q[15:0]);
    assign br_take = status_q[T_BIT] ^ w_data_q[BR_SENSE_BIT];
    assign stall = mem_q.req && !mem_ready;
    assign retire = clk_en && state_q == ST_EXEC && !stall && cnt_q == CYC_ONE;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            op_q <= 16'h0;
            dec_q <= '0;
            taken_q <= 1'b0;
            cnt_q <= 3'h0;
            cyc_q <= 8'h00;
            last_cyc_q <= 8'h00;
            illegal_q <= 1'b0;
        end else if (clk_en) begin
            unique case (state_q)
                ST_IDLE: begin
                    if (issue) begin
                        op_q <= w_data_q[15:0];
                        dec_q <= dec_new;
                        taken_q <= br_take;
                        illegal_q <= dec_new.kind == K_ILLEGAL;
                        cyc_q <= 8'h00;
                        if (dec_new.kind != K_ILLEGAL) begin
                            state_q <= ST_EXEC;
                            if (dec_new.kind == K_BRANCH && !br_take) cnt_q <= CYC_BR_NOT;
                            else cnt_q <= dec_new.cycles;
                        end
                    end
                end
                ST_EXEC: begin
                    cyc_q <= cyc_q + 8'h01;
                    if (retire) begin
                        state_q <= ST_IDLE;
                        last_cyc_q <= cyc_q + 8'h01;
                    end else if (!stall) cnt_q <= cnt_q - 3'h1;
                end
            endcase
        end
    end

    // ********
    // Memory port
    // ********
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mem_q <= '0;
        end else if (clk_en) begin
            if (issue && dec_new.kind == K_LOAD) begin
                mem_q <= '{1'b1, 1'b0, gpr_q[w_data_q[11:8]], 32'h0};
            end else if (issue && dec_new.kind == K_STORE) begin
                mem_q.req <= 1'b1;
                mem_q.we <= 1'b1;
                mem_q.addr <= gpr_q[w_data_q[11:8]] - GPR_STEP;
                mem_q.wdata <= dsp_q[dec_new.tgt];
            end else if (mem_q.req && mem_ready) mem_q.req <= 1'b0;
        end
    end

    // ********
    // DSP registers, status word, program counter
    // ********
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_DSP; i++) dsp_q[i] <= DSP_RST;
            status_q <= STATUS_RST;
            pc_q <= PC_RST;
        end else if (clk_en) begin
            if (mem_q.req && mem_ready && !mem_q.we) dsp_q[dec_q.tgt] <= mem_rdata;
            if (retire) begin
                case (dec_q.kind)
                    K_TO_DSP: dsp_q[dec_q.tgt] <= gpr_q[gpr_idx];
                    K_PCREL: dsp_q[dec_q.tgt] <= pc_q + disp2;
                    K_CNT_IMM: status_q[CNT_MSB:CNT_LSB] <= {4'h0, op_q[7:0]};
                    K_CNT_REG: status_q[CNT_MSB:CNT_LSB] <= gpr_q[gpr_idx][11:0];
                    default: ;
                endcase
                if (dec_q.kind == K_BRANCH && taken_q) pc_q <= pc_q + disp2;
                else pc_q <= pc_q + PC_STEP;
            end
            if (wr_fire && idle) begin
                if (aw_addr_q < OFS_STATUS && aw_addr_q[1:0] == 2'h0) begin
                    dsp_q[aw_addr_q[5:2]] <= merge(dsp_q[aw_addr_q[5:2]], w_data_q, w_strb_q);
                end else if (aw_addr_q == OFS_STATUS) begin
                    status_q <= merge(status_q, w_data_q, w_strb_q);
                end else if (aw_addr_q == OFS_PC) pc_q <= merge(pc_q, w_data_q, w_strb_q);
            end
        end
    end

    // ********
    // General registers
    // ********
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_GPR; i++) gpr_q[i] <= GPR_RST;
        end else if (clk_en) begin
            if (retire) begin
                case (dec_q.kind)
                    K_FROM_DSP: gpr_q[gpr_idx] <= dsp_q[dec_q.tgt];
                    K_LOAD: gpr_q[gpr_idx] <= gpr_q[gpr_idx] + GPR_STEP;
                    K_STORE: gpr_q[gpr_idx] <= gpr_q[gpr_idx] - GPR_STEP;
                    default: ;
                endcase
            end
            if (wr_fire && idle && aw_addr_q >= OFS_GPR_BASE && aw_addr_q <= OFS_GPR_END
                && aw_addr_q[1:0] == 2'h0) begin
                gpr_q[aw_addr_q[5:2]] <= merge(gpr_q[aw_addr_q[5:2]], w_data_q, w_strb_q);
            end
        end
    end

    // ********
    // AXI4-Lite slave
    // ********
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0;
            w_strb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_awvalid && awready_q) begin
                aw_hold_q <= 1'b1;
                awready_q <= 1'b0;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && wready_q) begin
                w_hold_q <= 1'b1;
                wready_q <= 1'b0;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q <= mapped(aw_addr_q) ? RESP_OKAY : RESP_DECERR;
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
            end
            if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_arvalid && arready_q) begin
                arready_q <= 1'b0;
                rvalid_q <= 1'b1;
                rdata_q <= rd_value(s_axi_araddr);
                rresp_q <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
            end else if (rvalid_q && s_axi_rready) begin
                rvalid_q <= 1'b0;
                arready_q <= 1'b1;
            end
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign mem_out = mem_q;

    // ********
    // Checks
    // ********
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    property p_wrap_cyc;
        retire && dec_q.kind == K_LOAD && dec_q.tgt == TGT_WRAP |-> cyc_q >= 8'h02;
    endproperty
    a_wrap_cyc: assert property (p_wrap_cyc) else $error("wrap load under three cycles");
    property p_fin_load;
        clk_en && mem_q.req && mem_ready && !mem_q.we && dec_q.tgt == TGT_FIN
            |=> dsp_q[TGT_FIN] == $past(mem_rdata);
    endproperty
    a_fin_load: assert property (p_fin_load) else $error("finish pointer load lost");
    property p_post_inc;
        retire && dec_q.kind == K_LOAD |=> gpr_q[gpr_idx] == $past(gpr_q[gpr_idx]) + GPR_STEP;
    endproperty
    a_post_inc: assert property (p_post_inc) else $error("post-increment wrong");
    property p_pcrel;
        retire && dec_q.kind == K_PCREL && dec_q.tgt == TGT_FIN
            |=> dsp_q[TGT_FIN] == $past(pc_q) + $past(disp2);
    endproperty
    a_pcrel: assert property (p_pcrel) else $error("pc-relative finish wrong");
    property p_dsr_one;
        issue && dec_new.kind == K_LOAD && dec_new.tgt == TGT_DSR
            |=> state_q == ST_EXEC && cnt_q == CYC_ONE;
    endproperty
    a_dsr_one: assert property (p_dsr_one) else $error("status load not one cycle");
    property p_cnt_imm;
        retire && dec_q.kind == K_CNT_IMM |=> status_q[CNT_IMM_MSB:CNT_LSB] == $past(op_q[7:0]);
    endproperty
    a_cnt_imm: assert property (p_cnt_imm) else $error("loop count wrong");
    property p_cnt_clr;
        retire && dec_q.kind == K_CNT_IMM |=> status_q[CNT_MSB:CNT_HI_LSB] == 4'h0;
    endproperty
    a_cnt_clr: assert property (p_cnt_clr) else $error("count high bits kept");
    property p_store_addr;
        issue && dec_new.kind == K_STORE
            |=> mem_q.req && mem_q.we && mem_q.addr == $past(gpr_q[w_data_q[11:8]]) - GPR_STEP;
    endproperty
    a_store_addr: assert property (p_store_addr) else $error("store address wrong");
    property p_br_not;
        retire && dec_q.kind == K_BRANCH && !taken_q |-> cyc_q == 8'h00;
    endproperty
    a_br_not: assert property (p_br_not) else $error("untaken branch too long");
    property p_move_to;
        retire && dec_q.kind == K_TO_DSP |=> dsp_q[$past(dec_q.tgt)] == $past(gpr_q[gpr_idx]);
    endproperty
    a_move_to: assert property (p_move_to) else $error("register move lost");
endmodule : dxd_decode

/* design/dxd_pkg.sv */
/*
 * Constants and types of the DSP extension instruction unit.
 * Assumes one 100 MHz core clock and an AXI4-Lite register master.
 */
package dxd_pkg;
    // ********
    // Register map
    // ********
    localparam logic [7:0] OFS_STATUS = 8'h24;
    localparam logic [7:0] OFS_PC = 8'h28;
    localparam logic [7:0] OFS_ISSUE = 8'h2C;
    localparam logic [7:0] OFS_EXEC = 8'h30;
    localparam logic [7:0] OFS_GPR_BASE = 8'h40;
    localparam logic [7:0] OFS_GPR_END = 8'h7C;
    localparam int EXEC_BUSY_BIT = 0;
    localparam int EXEC_ILLEGAL_BIT = 1;
    localparam int EXEC_CYC_LSB = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // ********
    // Fields and reset values
    // ********
    localparam int T_BIT = 0;
    localparam int BR_SENSE_BIT = 9;
    localparam int CNT_LSB = 16;
    localparam int CNT_IMM_MSB = 23;
    localparam int CNT_HI_LSB = 24;
    localparam int CNT_MSB = 27;
    localparam logic [31:0] STATUS_RST = 32'h0;
    localparam logic [31:0] DSP_RST = 32'h0;
    localparam logic [31:0] GPR_RST = 32'h0;
    localparam logic [31:0] PC_RST = 32'h0;
    localparam logic [31:0] GPR_STEP = 32'h4;
    localparam logic [31:0] PC_STEP = 32'h2;
    localparam int NUM_DSP = 9;
    localparam int NUM_GPR = 16;
    localparam logic [3:0] TGT_WRAP = 4'h0;
    localparam logic [3:0] TGT_FIN = 4'h1;
    localparam logic [3:0] TGT_START = 4'h2;
    localparam logic [3:0] TGT_DSR = 4'h3;
    // ********
    // Opcode fields
    // ********
    localparam logic [7:0] HB_LDFIN_PC = 8'h8E;
    localparam logic [7:0] HB_LDST_PC = 8'h8C;
    localparam logic [7:0] HB_CNT_IMM = 8'h82;
    localparam logic [7:0] HB_BT_S = 8'h8D;
    localparam logic [7:0] HB_BF_S = 8'h8F;
    localparam logic [3:0] GRP_SYS = 4'h4;
    localparam logic [3:0] GRP_MOV = 4'h0;
    localparam logic [7:0] LO_CNT_REG = 8'h14;
    localparam logic [3:0] NIB_CTL_MOVE = 4'hE;
    localparam logic [3:0] NIB_CTL_LOAD = 4'h7;
    localparam logic [3:0] NIB_CTL_STORE = 4'h3;
    localparam logic [3:0] NIB_CTL_READ = 4'h2;
    localparam logic [3:0] NIB_SYS_MOVE = 4'hA;
    localparam logic [3:0] NIB_SYS_LOAD = 4'h6;
    localparam logic [3:0] NIB_SYS_STORE = 4'h2;
    localparam logic [3:0] CTL_SEL_WRAP = 4'h5;
    localparam logic [3:0] CTL_SEL_START = 4'h6;
    localparam logic [3:0] CTL_SEL_FIN = 4'h7;
    localparam logic [3:0] SYS_SEL_LO = 4'h6;
    localparam logic [3:0] SYS_SEL_HI = 4'hB;
    localparam logic [3:0] SYS_SEL_BIAS = 4'h3;
    // ********
    // Cycle counts
    // ********
    localparam logic [2:0] CYC_ONE = 3'h1;
    localparam logic [2:0] CYC_CTL_LOAD = 3'h3;
    localparam logic [2:0] CYC_CTL_STORE = 3'h2;
    localparam logic [2:0] CYC_BR_TAKEN = 3'h2;
    localparam logic [2:0] CYC_BR_NOT = 3'h1;
    // ********
    // Types
    // ********
    typedef enum logic [3:0] {
        K_ILLEGAL = 4'h0, K_TO_DSP = 4'h1, K_FROM_DSP = 4'h2, K_LOAD = 4'h3, K_STORE = 4'h4,
        K_PCREL = 4'h5, K_CNT_IMM = 4'h6, K_CNT_REG = 4'h7, K_BRANCH = 4'h8
    } dxd_kind_type;
    typedef struct packed {
        dxd_kind_type kind;
        logic [3:0] tgt;
        logic [2:0] cycles;
    } dxd_dec_type;
    typedef struct packed {
        logic req;
        logic we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } dxd_mem_type;
    typedef enum logic {ST_IDLE = 1'b0, ST_EXEC = 1'b1} dxd_state_type;
endpackage : dxd_pkg

/* tb/dxd_mem_model.sv */
/*
 * Data memory model for the DSP extension unit.
 * Assumes one clock; slow holds off ready for one cycle per request.
 */
`timescale 1ns/1ps
module dxd_mem_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire dxd_pkg::dxd_mem_type mem_out,
    input wire logic slow,
    output logic mem_ready,
    output logic [31:0] mem_rdata
);
    import dxd_pkg::*;
    // ********
    // Storage and answer
    // ********
    logic [31:0] mem [64];
    logic wait_q;
    assign mem_ready = mem_out.req & (~slow | wait_q);
    // Data not valid while stalled: inverse of the word
    assign mem_rdata = mem_ready ? mem[mem_out.addr[7:2]] : ~mem[mem_out.addr[7:2]];
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) wait_q <= 1'b0;
        else wait_q <= mem_out.req & ~mem_ready;
    end
    always @(posedge core_clk) begin
        if (mem_ready & mem_out.we) mem[mem_out.addr[7:2]] <= mem_out.wdata;
    end
    initial for (int i = 0; i < 64; i++) mem[i] = 32'h5A00_0000 + i;
endmodule : dxd_mem_model

/* tb/dxd_decode_bench.sv */
/*
 * Self-checking bench of the DSP extension unit.
 * Assumes the memory model and AXI4-Lite slave timing of the unit.
 */
`timescale 1ns/1ps
module dxd_decode_bench;
    import dxd_pkg::*;
    // ********
    // Signals and instances
    // ********
    logic core_clk = 1'b0, rst = 1'b1, slow = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
    logic arvalid = 1'b0, clk_en = 1'b1, awready, wready, bvalid, arready, rvalid, mem_ready;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, mem_rdata, v;
    logic [1:0] bresp, rresp, r;
    dxd_mem_type mem_out;
    int fail_count = 0, compares = 0, cyc = 0;
    dxd_decode u_dxd_decode (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .mem_out(mem_out),
        .mem_ready(mem_ready), .mem_rdata(mem_rdata));
    dxd_mem_model u_dxd_mem_model (.core_clk(core_clk), .rst(rst), .mem_out(mem_out),
        .slow(slow), .mem_ready(mem_ready), .mem_rdata(mem_rdata));
    // ********
    // Shared tasks
    // ********
    task automatic final_report;
        $display("mismatches %0d comparisons %0d", fail_count, compares);
        if (fail_count == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge core_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge core_clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        v = rdata;
        r = rresp;
    endtask : rd
    task automatic run(input logic [15:0] op, input logic [31:0] n, input int f = 0);
        wr(OFS_ISSUE, {16'h0, op});
        if (f > 0) begin
            clk_en <= 1'b0;
            repeat (f) @(posedge core_clk);
            clk_en <= 1'b1;
        end
        do rd(OFS_EXEC); while (v[EXEC_BUSY_BIT] !== 1'b0);
        chk({24'h0, v[15:8]}, n);
    endtask : run
    // ********
    // Scenarios
    // ********
    task automatic t_loads;
        logic [7:0] lo [9] = '{8'h57, 8'h77, 8'h67, 8'h66, 8'h76, 8'h86, 8'h96, 8'hA6, 8'hB6};
        wr(8'h48, 32'h10);
        for (int i = 0; i < 9; i++) begin
            slow <= (i == 0);
            run({8'h42, lo[i]}, (i < 3 ? 3 : 1) + (i == 0));
            rd(8'(4 * i));
            chk(v, 32'h5A00_0004 + i);
        end
        slow <= 1'b0;
        rd(8'h48);
        chk(v, 32'h34);
    endtask : t_loads
    task automatic t_stores;
        logic [7:0] st [3] = '{8'h53, 8'h73, 8'h63};
        wr(8'h4C, 32'h80);
        for (int i = 0; i < 3; i++) begin
            run({8'h43, st[i]}, 2);
            chk(u_dxd_mem_model.mem[31 - i], 32'h5A00_0004 + i);
        end
        rd(8'h4C);
        chk(v, 32'h74);
    endtask : t_stores
    task automatic t_pcrel;
        wr(OFS_PC, 32'h100);
        run(16'h8E10, 1);
        rd(8'h04);
        chk(v, 32'h120);
        run(16'h8CF0, 1);
        rd(8'h08);
        chk(v, 32'hE2);
    endtask : t_pcrel
    task automatic t_set_loop_count;
        wr(OFS_STATUS, 32'h0F00_0000);
        run(16'h825A, 1);
        rd(OFS_STATUS);
        chk(v, 32'h005A_0000);
        wr(8'h50, 32'hABC5);
        run(16'h4414, 1);
        rd(OFS_STATUS);
        chk(v, 32'h0BC5_0000);
    endtask : t_set_loop_count
    task automatic t_branch;
        wr(OFS_STATUS, 32'h1);
        run(16'h8D02, 2);
        run(16'h8F02, 1);
        run(16'h8D02, 2, 4);
    endtask : t_branch
    task automatic t_moves;
        wr(8'h54, 32'hCAFE_0001);
        run(16'h457A, 1);
        run(16'h067A, 1);
        rd(8'h58);
        chk(v, 32'hCAFE_0001);
        run(16'h455E, 1);
        rd(8'h00);
        chk(v, 32'hCAFE_0001);
    endtask : t_moves
    task automatic t_refuse;
        wr(8'h80, 32'h1);
        chk(32'(r), 32'(RESP_DECERR));
        rd(8'h80);
        chk(32'(r), 32'(RESP_DECERR));
        wr(OFS_EXEC, 32'h0);
        chk(32'(r), 32'(RESP_OKAY));
        wr(OFS_ISSUE, 32'hFFFF);
        rd(OFS_EXEC);
        chk(32'(r), 32'(RESP_OKAY));
        chk(32'(v[EXEC_ILLEGAL_BIT]), 32'h1);
    endtask : t_refuse
    // ********
    // Clock, timeout and sequence
    // ********
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            final_report();
        end
    end
    initial begin
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        t_loads();
        t_stores();
        t_pcrel();
        t_set_loop_count();
        t_branch();
        t_moves();
        t_refuse();
        final_report();
    end
endmodule : dxd_decode_bench
